// ### core/alarm_fault_relay_control.sv
// Purpose: Drives two alarm relays and one fault relay
// Assumes: Inputs synchronous to clk_sys; classic Wishbone slave
// Notes: Relay outputs are coil drives, high means coil on
// Notes on behaviour
// RQ1: Three relays: two alarms, one fault
// RQ2: Normal polarity: alarm coil off when clear
// RQ3: Alarm activates after over five seconds
// RQ4: Normal polarity: fault coil off when clear
// RQ5: Fault activates after over five seconds
// RQ6: Energized polarity inverts the coil drive
// RQ7: Non-latching relay drops when condition clears
// RQ8: Latching relay stays active after clearing
// RQ9: Only a magnet swipe releases a latch
// RQ10: Ascending trips above the threshold
// RQ11: Descending trips below the threshold
// RQ12: No activation in first sixty seconds
// RQ13: Timer restarts when condition drops early
//
// The register addresses and register access over Wishbone were left to the implementer.
`timescale 1ns/100ps
`default_nettype none

module alarm_fault_relay_control
  import relay_ctrl_pkg::*;
#(
  parameter int unsigned QUAL_CNT = QUAL_CYCLES,
  parameter int unsigned INHIBIT_CNT = INHIBIT_CYCLES
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic [CONC_W-1:0] concentration,
  input wire logic fault_in,
  input wire logic magnet_switch_upper,
  input wire logic magnet_switch_lower,
  output logic [NUM_RELAYS-1:0] relay_coil,
  output logic irq
);

  // Byte-lane merge of a write into an old word
  function automatic logic [31:0] merge_sel(
    input logic [31:0] old_w,
    input logic [31:0] new_w,
    input logic [3:0] sel
  );
    logic [31:0] res;
    res = old_w;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        res[8*b +: 8] = new_w[8*b +: 8];
      end
    end
    return res;
  endfunction

  // Trip test for one alarm relay
  function automatic logic trip(
    input logic [CONC_W-1:0] conc,
    input logic [CONC_W-1:0] thr,
    input logic desc
  );
    logic hit;
    // RQ11: below when descending
    // RQ10: above when ascending
    hit = desc ? (conc < thr) : (conc > thr);
    return hit;
  endfunction

  relay_cfg_t cfg;
  logic [CONC_W-1:0] thr1;
  logic [CONC_W-1:0] thr2;
  logic [NUM_RELAYS-1:0] irq_mask;
  logic [NUM_RELAYS-1:0] irq_stat;
  logic [NUM_RELAYS-1:0] next_irq_stat;
  logic [NUM_RELAYS-1:0] cond;
  logic [NUM_RELAYS-1:0] qual;
  logic [NUM_RELAYS-1:0] latched;
  logic [NUM_RELAYS-1:0] active;
  logic [NUM_RELAYS-1:0] next_active;
  logic [31:0] qual_cnt [NUM_RELAYS];
  logic [31:0] inhibit_cnt;
  pwr_state_t pwr_state;
  logic run;
  logic upper_q;
  logic lower_q;
  logic swipe;
  logic bus_req;
  logic wr_stb;
  logic rd_stb;
  logic [31:0] rd_word;
  logic [31:0] wr_ctrl;
  logic [31:0] wr_thr1;
  logic [31:0] wr_thr2;
  logic [31:0] wr_mask;
  relay_status_t stat;

  // Bus strobes, one per access on the edge that raises ack
  assign bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wr_stb = bus_req && wb_we_i;
  assign rd_stb = bus_req && !wb_we_i;
  assign run = (pwr_state == PWR_RUN);

  // Merged write words
  assign wr_ctrl = merge_sel({24'h00_0000, cfg}, wb_dat_i, wb_sel_i);
  assign wr_thr1 = merge_sel({16'h0000, thr1}, wb_dat_i, wb_sel_i);
  assign wr_thr2 = merge_sel({16'h0000, thr2}, wb_dat_i, wb_sel_i);
  assign wr_mask = merge_sel({29'h0, irq_mask}, wb_dat_i, wb_sel_i);

  // RQ1: three trigger conditions
  // Alarm conditions from thresholds, fault taken directly
  always_comb begin
    cond[RELAY_ALM1] = trip(concentration, thr1, cfg.descend[0]);
    cond[RELAY_ALM2] = trip(concentration, thr2, cfg.descend[1]);
    cond[RELAY_FLT] = fault_in;
  end

  // Power-up inhibit sequence
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      pwr_state <= PWR_INHIBIT;
      inhibit_cnt <= 32'h0000_0000;
    end else begin
      case (pwr_state)
        PWR_INHIBIT: begin
          // RQ12: hold off sixty seconds
          if (inhibit_cnt >= INHIBIT_CNT - 1) begin
            pwr_state <= PWR_RUN;
          end else begin
            inhibit_cnt <= inhibit_cnt + 32'h0000_0001;
          end
        end
        PWR_RUN: begin
          pwr_state <= PWR_RUN;
        end
        default: begin
          pwr_state <= PWR_INHIBIT;
        end
      endcase
    end
  end

  // Persistence timers, saturating at the qualification count
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      for (int i = 0; i < NUM_RELAYS; i++) begin
        qual_cnt[i] <= 32'h0000_0000;
      end
    end else begin
      for (int i = 0; i < NUM_RELAYS; i++) begin
        // RQ13: restart on dropout
        if (!cond[i]) begin
          qual_cnt[i] <= 32'h0000_0000;
        end else if (qual_cnt[i] < QUAL_CNT) begin
          qual_cnt[i] <= qual_cnt[i] + 32'h0000_0001;
        end
      end
    end
  end

  // RQ3: alarm needs the full period
  // RQ5: fault needs the full period
  always_comb begin
    for (int i = 0; i < NUM_RELAYS; i++) begin
      qual[i] = cond[i] && (qual_cnt[i] >= QUAL_CNT);
    end
  end

  // Magnet swipe: rising edge on either switch
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      upper_q <= 1'b0;
      lower_q <= 1'b0;
    end else begin
      upper_q <= magnet_switch_upper;
      lower_q <= magnet_switch_lower;
    end
  end
  assign swipe = (magnet_switch_upper && !upper_q) ||
                 (magnet_switch_lower && !lower_q);

  // Latch memory per relay, set wins over a swipe
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      latched <= '0;
    end else begin
      for (int i = 0; i < NUM_RELAYS; i++) begin
        // RQ8: hold after clearing
        if (run && cfg.latching[i] && qual[i]) begin
          latched[i] <= 1'b1;
        // RQ9: released by a swipe only
        end else if (swipe) begin
          latched[i] <= 1'b0;
        end
      end
    end
  end

  // Activation, gated off while the inhibit runs
  always_comb begin
    for (int i = 0; i < NUM_RELAYS; i++) begin
      // RQ7: drop as soon as clear
      // RQ12: nothing active while inhibited
      next_active[i] = run && (qual[i] || latched[i]);
    end
  end

  // Relay state and coil drive
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      active <= '0;
      relay_coil <= '0;
    end else begin
      active <= next_active;
      // RQ6: energized mode inverts
      // RQ2: alarm coil off when clear
      // RQ4: fault coil off when clear
      relay_coil <= next_active ^ cfg.energized;
    end
  end

  // Sticky activation events, cleared by an interrupt status read
  always_comb begin
    next_irq_stat = irq_stat;
    if (rd_stb && wb_adr_i == ADDR_IRQ_STAT) begin
      next_irq_stat = '0;
    end
    next_irq_stat = next_irq_stat | (next_active & ~active);
  end

  // Interrupt status and level output
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      irq_stat <= '0;
      irq <= 1'b0;
    end else begin
      irq_stat <= next_irq_stat;
      irq <= |(next_irq_stat & irq_mask);
    end
  end

  // Configuration registers written from the bus
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      cfg <= CTRL_RESET;
      thr1 <= THR_RESET;
      thr2 <= THR_RESET;
      irq_mask <= MASK_RESET;
    end else if (wr_stb) begin
      case (wb_adr_i)
        ADDR_CTRL: cfg <= wr_ctrl[7:0];
        ADDR_THR1: thr1 <= wr_thr1[CONC_W-1:0];
        ADDR_THR2: thr2 <= wr_thr2[CONC_W-1:0];
        ADDR_IRQ_MASK: irq_mask <= wr_mask[NUM_RELAYS-1:0];
        default: begin
        end
      endcase
    end
  end

  // Read mux, unmapped offsets read zero
  always_comb begin
    stat.inhibit_done = run;
    stat.cond = cond;
    stat.active = active;
    case (wb_adr_i)
      ADDR_CTRL: rd_word = {24'h00_0000, cfg};
      ADDR_THR1: rd_word = {16'h0000, thr1};
      ADDR_THR2: rd_word = {16'h0000, thr2};
      ADDR_STATUS: rd_word = {25'h000_0000, stat};
      ADDR_IRQ_STAT: rd_word = {29'h0000_0000, irq_stat};
      ADDR_IRQ_MASK: rd_word = {29'h0000_0000, irq_mask};
      default: rd_word = 32'h0000_0000;
    endcase
  end

  // Bus answer: ack one cycle after the request, for one cycle
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= bus_req;
      if (rd_stb) begin
        wb_dat_o <= rd_word;
      end
    end
  end

endmodule

`default_nettype wire

// ### core/relay_ctrl_pkg.sv
// Purpose: Shared constants and types for the relay controller
// Assumes: 10 MHz system clock, 32-bit classic Wishbone bus
// Notes: Register offsets are byte addresses of aligned words
package relay_ctrl_pkg;

  // Clock rate and documented times
  localparam int unsigned CLK_HZ = 10_000_000;
  localparam int unsigned QUAL_TIME_S = 5;
  localparam int unsigned INHIBIT_TIME_S = 60;
  // Times as cycle counts
  localparam int unsigned QUAL_CYCLES = QUAL_TIME_S * CLK_HZ;
  localparam int unsigned INHIBIT_CYCLES = INHIBIT_TIME_S * CLK_HZ;

  // Relay indices
  localparam int NUM_RELAYS = 3;
  localparam int RELAY_ALM1 = 0;
  localparam int RELAY_ALM2 = 1;
  localparam int RELAY_FLT = 2;
  localparam int CONC_W = 16;

  // Register offsets
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_THR1 = 8'h04;
  localparam logic [7:0] ADDR_THR2 = 8'h08;
  localparam logic [7:0] ADDR_STATUS = 8'h0C;
  localparam logic [7:0] ADDR_IRQ_STAT = 8'h10;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h14;

  // Reset values
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [15:0] THR_RESET = 16'h0000;
  localparam logic [2:0] MASK_RESET = 3'h0;

  // Per-relay configuration: bits [2:0] energized, [5:3] latching,
  // [7:6] descending trip for the two alarm relays
  typedef struct packed {
    logic [1:0] descend;
    logic [2:0] latching;
    logic [2:0] energized;
  } relay_cfg_t;

  // Live state: bits [2:0] active, [5:3] condition, [6] inhibit over
  typedef struct packed {
    logic inhibit_done;
    logic [2:0] cond;
    logic [2:0] active;
  } relay_status_t;

  // Power-up sequence
  typedef enum logic [1:0] {
    PWR_INHIBIT = 2'b00,
    PWR_RUN = 2'b01
  } pwr_state_t;

endpackage

// ### verif/magnet_tool.sv
// Purpose: Magnet tool over the two switches
// Assumes: Swipe request is a one-cycle pulse
// Notes: Each switch stays closed two cycles
`timescale 1ns/100ps
`default_nettype none
module magnet_tool (
  input wire logic clk_sys,
  input wire logic [1:0] swipe,
  output logic up,
  output logic lo
);
  logic [1:0] h = 2'b00;
  always @(posedge clk_sys) begin
    h <= swipe;
  end
  assign up = swipe[0] | h[0];
  assign lo = swipe[1] | h[1];
endmodule
`default_nettype wire

// ### verif/relay_props.sv
// Purpose: Port checks for the relay controller
// Assumes: Bus writes use all byte lanes
// Notes: Shadows the control word from bus writes
`timescale 1ns/100ps
`default_nettype none
module relay_props
  import relay_ctrl_pkg::*;
#(
  parameter int unsigned QUAL_CNT = 4,
  parameter int unsigned INHIBIT_CNT = 8
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic wb_ack_o,
  input wire logic fault_in,
  input wire logic magnet_switch_upper,
  input wire logic magnet_switch_lower,
  input wire logic [NUM_RELAYS-1:0] relay_coil,
  input wire logic irq
);
  localparam int SETTLE = INHIBIT_CNT + QUAL_CNT + 2;
  logic [7:0] ctrl;
  logic [7:0] c1;
  logic [7:0] c2;
  logic [7:0] inh;
  logic [7:0] fc;
  logic calm;
  logic fact;
  logic swp;
  // Calm means control unchanged for two cycles, so coil lag is settled
  assign calm = ctrl == c1 && c1 == c2;
  assign fact = relay_coil[2] ^ ctrl[2];
  assign swp = magnet_switch_upper | magnet_switch_lower;
  // Control shadow, time since reset, fault run length
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      ctrl <= 8'h00;
      c1 <= 8'h00;
      c2 <= 8'h00;
      inh <= 8'h00;
      fc <= 8'h00;
    end else begin
      if (wb_cyc_i && wb_stb_i && !wb_ack_o && wb_we_i
          && wb_adr_i == ADDR_CTRL) begin
        ctrl <= wb_dat_i[7:0];
      end
      c1 <= ctrl;
      c2 <= c1;
      inh <= (inh == 8'hFF) ? inh : inh + 8'h01;
      fc <= !fault_in ? 8'h00 : (fc == 8'hFF) ? fc : fc + 8'h01;
    end
  end
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);
  ack_follow_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o
    |=> wb_ack_o) else $error("ack late");
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack too long");
  inhibit_coil_a: assert property (
    inh < INHIBIT_CNT |-> relay_coil == ctrl[2:0])
    else $error("coil moved in inhibit");
  irq_quiet_a: assert property (
    inh < INHIBIT_CNT |-> !irq) else $error("irq in inhibit");
  fault_qual_a: assert property (
    $rose(fact) && calm |-> $past(fc) >= QUAL_CNT)
    else $error("fault relay early");
  fault_on_a: assert property (
    inh > SETTLE && fc > QUAL_CNT + 1 && calm |-> fact)
    else $error("fault relay late");
  fault_drop_a: assert property (
    fact && !fault_in && !ctrl[5] && calm |=> !fact)
    else $error("fault relay stuck");
  latch_hold_a: assert property (
    fact && ctrl[5] && calm && !swp |=> fact)
    else $error("latch lost");
  cover property ($rose(fact));
  cover property ($fell(fact) && ctrl[5]);
  cover property (fc > QUAL_CNT && inh < INHIBIT_CNT);
endmodule
bind alarm_fault_relay_control relay_props #(.QUAL_CNT(QUAL_CNT),
  .INHIBIT_CNT(INHIBIT_CNT)) props_u (.clk_sys(clk_sys), .rst_n(rst_n),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
  .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_ack_o(wb_ack_o),
  .fault_in(fault_in), .magnet_switch_upper(magnet_switch_upper),
  .magnet_switch_lower(magnet_switch_lower), .relay_coil(relay_coil),
  .irq(irq));
`default_nettype wire

// ### verif/testbench.sv
// Purpose: Self-checking bench for the relay controller
// Assumes: Qualify count 4, inhibit count 8
// Notes: Fault input is high from time zero
`timescale 1ns/100ps
`default_nettype none
module testbench
  import relay_ctrl_pkg::*;
;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic cyc = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [31:0] di = 32'h0;
  logic [31:0] dq;
  logic ack;
  logic [15:0] conc = 16'h0000;
  logic flt = 1'b1;
  logic [1:0] sw = 2'b00;
  logic up;
  logic lo;
  logic [2:0] coil;
  logic irq;
  int failures = 0;
  int samples_checked = 0;
  // Clock of 100 ns
  always #50 clk_sys = ~clk_sys;
  magnet_tool tool_u (.clk_sys(clk_sys), .swipe(sw), .up(up), .lo(lo));
  alarm_fault_relay_control #(.QUAL_CNT(4), .INHIBIT_CNT(8)) dut_u (
    .clk_sys(clk_sys), .rst_n(rst_n), .wb_cyc_i(cyc), .wb_stb_i(cyc),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(di),
    .wb_dat_o(dq), .wb_ack_o(ack), .concentration(conc),
    .fault_in(flt), .magnet_switch_upper(up), .magnet_switch_lower(lo),
    .relay_coil(coil), .irq(irq));
  task automatic tally_and_finish;
    if (failures == 0 && samples_checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic ck(input string n, input logic [31:0] e,
      input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      failures++;
      $display("BAD %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic tk(input int n);
    repeat (n) @(posedge clk_sys);
  endtask
  // Classic single cycle; read data compared with e
  task automatic bus(input logic w, input logic [7:0] a,
      input logic [31:0] d, input logic [31:0] e);
    int k;
    k = 0;
    cyc <= 1'b1;
    we <= w;
    adr <= a;
    di <= d;
    do begin
      @(posedge clk_sys);
      k++;
    end while (ack !== 1'b1 && k < 20);
    if (ack !== 1'b1) begin
      failures++;
      tally_and_finish();
    end else begin
      if (!w) begin
        ck("read", e, dq);
      end
      cyc <= 1'b0;
      @(posedge clk_sys);
    end
  endtask
  // Coil just before and just after qualification
  task automatic ql(input logic [2:0] off, input logic [2:0] on);
    tk(5);
    ck("coil", 32'(off), 32'(coil));
    tk(1);
    ck("coil", 32'(on), 32'(coil));
  endtask
  initial begin
    tk(20);
    rst_n <= 1'b1;
    tk(4);
    ck("coil", 32'h0, 32'(coil));
    tk(10);
    ck("coil", 32'h4, 32'(coil));
    bus(1'b0, ADDR_STATUS, 32'h0, 32'h0000_0064);
    bus(1'b0, ADDR_CTRL, 32'h0, 32'h0);
    bus(1'b0, ADDR_THR1, 32'h0, 32'h0);
    bus(1'b0, 8'h18, 32'h0, 32'h0);
    ck("irq", 32'h0, 32'(irq));
    bus(1'b1, ADDR_IRQ_MASK, 32'h7, 32'h0);
    ck("irq", 32'h1, 32'(irq));
    bus(1'b0, ADDR_IRQ_STAT, 32'h0, 32'h4);
    ck("irq", 32'h0, 32'(irq));
    bus(1'b0, ADDR_IRQ_STAT, 32'h0, 32'h0);
    flt <= 1'b0;
    tk(1);
    ck("coil", 32'h4, 32'(coil));
    tk(1);
    ck("coil", 32'h0, 32'(coil));
    flt <= 1'b1;
    tk(3);
    flt <= 1'b0;
    tk(1);
    flt <= 1'b1;
    ql(3'b000, 3'b100);
    flt <= 1'b0;
    bus(1'b1, ADDR_THR2, 32'h0000_FFFF, 32'h0);
    bus(1'b1, ADDR_THR1, 32'h0000_0064, 32'h0);
    conc <= 16'h0065;
    ql(3'b000, 3'b001);
    conc <= 16'h0064;
    tk(2);
    ck("coil", 32'h0, 32'(coil));
    bus(1'b1, ADDR_CTRL, 32'h0000_0040, 32'h0);
    conc <= 16'h0063;
    ql(3'b000, 3'b001);
    conc <= 16'h0064;
    bus(1'b1, ADDR_CTRL, 32'h0000_0024, 32'h0);
    ck("coil", 32'h4, 32'(coil));
    for (int i = 0; i < 2; i++) begin
      flt <= 1'b1;
      ql(3'b100, 3'b000);
      flt <= 1'b0;
      tk(6);
      ck("coil", 32'h0, 32'(coil));
      sw <= (i == 0) ? 2'b01 : 2'b10;
      tk(1);
      sw <= 2'b00;
      tk(4);
      ck("coil", 32'h4, 32'(coil));
    end
    // Second alarm relay, descending, with the concentration under its limit
    bus(1'b1, ADDR_CTRL, 32'h0000_0080, 32'h0);
    tk(3);
    ck("coil", 32'h0, 32'(coil));
    tk(1);
    ck("coil", 32'h2, 32'(coil));
    tally_and_finish();
  end
endmodule
`default_nettype wire
